// ===== dv/ptcrs_chk.sv
// Concurrent checks on the timestamp control block ports
`timescale 1ns/1ps
module ptcrs_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus side
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    // Frame and time side
    input wire logic rx_frame_done,
    input wire logic [15:0] rx_ethertype,
    input wire logic timestamping_enable,
    input wire logic timing_frame_addr_filter_en,
    input wire logic snapshot_take,
    input wire logic [31:0] snapshot_seconds,
    input wire logic target_time_irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Bus answer shape
    chk_ready_after_setup: assert property (psel && !penable |=> pready && penable)
        else $error("No ready after setup");
    chk_ready_in_access: assert property (pready |-> penable && $past(psel && !penable))
        else $error("Ready outside access");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("Ready longer than one cycle");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("Error without ready");
    chk_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("Read data not zero when idle");
    // Snapshot, filter and target pulse
    chk_snap_needs_enable: assert property (
        snapshot_take |-> $past(rx_frame_done && timestamping_enable))
        else $error("Snapshot without enabled frame");
    chk_snap_time_held: assert property ($changed(snapshot_seconds) |-> snapshot_take)
        else $error("Snapshot time moved without snapshot");
    chk_filter_type: assert property (
        timing_frame_addr_filter_en |-> $past(rx_ethertype) == 16'h88f7)
        else $error("Filter enable on other ethertype");
    chk_target_pulse: assert property (target_time_irq |=> !target_time_irq)
        else $error("Target pulse longer than one cycle");
endmodule : ptcrs_chk

bind ptcrs_top ptcrs_chk i_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .prdata,
    .rx_frame_done, .rx_ethertype, .timestamping_enable, .timing_frame_addr_filter_en,
    .snapshot_take, .snapshot_seconds, .target_time_irq);

// ===== dv/ptp_timestamp_ctrl_rx_stats_bench.sv
// Self-checking bench for the timestamp control and statistics block
`timescale 1ns/1ps
`define CHK(n, e, g) \
    begin \
        checked++; \
        if ((g) !== (e)) \
        begin \
            err_count++; \
            $display("[FAIL] %s exp %h got %h", n, e, g); \
        end \
    end
module ptp_timestamp_ctrl_rx_stats_bench;
    import ptcrs_pkg::*;
    localparam logic [11:0] CT = PTCRS_TS_CTRL_OFS;
    // Inputs, defined from time zero
    logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic rx_frame_done = '0, rx_crc_error = '0, rx_align_error = '0, rx_good_unicast = '0;
    logic rx_is_ptp = '0, rx_ptp_ipv4 = '0, rx_ptp_ipv6 = '0, rx_ptp_raw = '0;
    logic [15:0] rx_ethertype = '0;
    logic [3:0] rx_ptp_version = '0, rx_ptp_msg_type = '0;
    // Outputs and bench state
    logic [31:0] prdata, snapshot_seconds, rq, t0;
    logic [30:0] snapshot_subseconds;
    logic pready, pslverr, timestamping_enable, timing_frame_addr_filter_en;
    logic snapshot_take, target_time_irq, counter_irq, re, snap, hit;
    int err_count = 0, checked = 0;
    logic [3:0] msgs [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hb};

    // Small counters so wrap and half-max are reachable
    ptcrs_top #(.CNT_WIDTH(4)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .rx_frame_done, .rx_crc_error, .rx_align_error,
        .rx_good_unicast, .rx_ethertype, .rx_is_ptp, .rx_ptp_ipv4, .rx_ptp_ipv6, .rx_ptp_raw,
        .rx_ptp_version, .rx_ptp_msg_type, .timestamping_enable, .timing_frame_addr_filter_en,
        .snapshot_take, .snapshot_seconds, .snapshot_subseconds, .target_time_irq, .counter_irq);

    // 200 MHz clock
    initial forever #2.5 pclk = ~pclk;

    // One bus transfer, idle edge first so no signal is driven twice in a step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Wait until pready is seen high; the hang guard ends a stuck wait
        do @(posedge pclk); while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd
    // Update value then control write
    task automatic tset(input logic [31:0] s, input logic [31:0] ss, input logic [31:0] c);
        wr(PTCRS_ADJ_SEC_OFS, s);
        wr(PTCRS_ADJ_SUBSEC_OFS, ss);
        rd(CT);
        `CHK("req idle", 2'h0, rq[3:2])
        wr(CT, c);
    endtask : tset
    // Subsecond advance over six cycles
    task automatic step;
        rd(PTCRS_TIME_SUBSEC_OFS);
        t0 = rq;
        rd(PTCRS_TIME_SUBSEC_OFS);
        rd(PTCRS_TIME_SUBSEC_OFS);
        rq = rq - t0;
    endtask : step
    // Twenty cycles, noting any target pulse
    task automatic wt;
        hit = 1'b0;
        repeat (20)
        begin
            @(posedge pclk);
            hit |= target_time_irq;
        end
    endtask : wt
    // One frame end; flags crc, align, ucast, ptp, v4, v6, raw
    task automatic frm(input logic [6:0] f, input logic [3:0] v, input logic [3:0] m);
        {rx_frame_done, rx_crc_error, rx_align_error, rx_good_unicast, rx_is_ptp, rx_ptp_ipv4,
            rx_ptp_ipv6, rx_ptp_raw, rx_ptp_version, rx_ptp_msg_type} <= {1'b1, f, v, m};
        @(posedge pclk);
        rx_frame_done <= 1'b0;
        @(posedge pclk);
        snap = snapshot_take;
    endtask : frm
    // Snapshot table: c = node type, master, event-only
    function automatic logic exp_snap(input logic [3:0] c, input logic [3:0] m);
        logic base;
        base = m inside {4'h0, 4'h1, 4'h8, 4'h9};
        if (!c[0])
            return base || (c[3:2] == 2'h3 && m inside {4'h2, 4'h3});
        if (c[3:2] < 2'h2)
            return m == (c[1] ? 4'h1 : 4'h0);
        if (c[3:2] == 2'h2)
            return m inside {4'h0, 4'h8};
        return m inside {4'h0, 4'h2, 4'h3};
    endfunction : exp_snap
    task automatic tc(input logic [31:0] c, input logic [6:0] f, input logic [3:0] v,
            input logic e);
        wr(CT, c);
        frm(f, v, 4'h0);
        `CHK("transport snap", e, snap)
    endtask : tc

    // Reset values, counters, wrap, half-max flag, bus refusals
    task automatic t_count;
        rd(CT);
        `CHK("ctrl reset", 32'h0000_2000, rq)
        rd(12'h194);
        `CHK("crc reset", 32'h0, rq)
        for (int k = 0; k < 9; k++)
            frm({1'b1, k < 3, k < 2, 4'h0}, 4'h0, 4'h0);
        rd(12'h194);
        `CHK("crc count", 32'h9, rq)
        `CHK("half irq", 1'b1, counter_irq)
        wr(12'h198, 32'hffff_ffff);
        rd(12'h198);
        `CHK("align count", 32'h3, rq)
        rd(12'h1c4);
        `CHK("ucast count", 32'h2, rq)
        wr(12'h10c, 32'h20);
        rd(12'h108);
        `CHK("half status", 32'h20, rq)
        `CHK("masked irq", 1'b0, counter_irq)
        for (int k = 0; k < 7; k++)
            frm(7'h40, 4'h0, 4'h0);
        rd(12'h194);
        `CHK("crc wrap", 32'h0, rq)
        rd(12'h7f0);
        `CHK("unmapped", {1'b1, 32'h0}, {re, rq})
    endtask : t_count

    // Init, adjust, rollover, coarse and fine time, addend, target
    task automatic t_time;
        tset(32'h5, 32'h1234, 32'h0000_2005);
        rd(CT);
        `CHK("init clear", 32'h0000_2001, rq)
        `CHK("ts enable", 1'b1, timestamping_enable)
        rd(PTCRS_TIME_SEC_OFS);
        `CHK("init sec", 32'h5, rq)
        frm(7'h0c, 4'h1, 4'h0);
        `CHK("snap sec", 32'h5, snapshot_seconds)
        `CHK("snap subsec", 31'h1234, snapshot_subseconds)
        // Add with subsecond carry, then subtract with borrow
        tset(32'h3, 32'h7fff_ff00, 32'h0000_2009);
        rd(PTCRS_TIME_SEC_OFS);
        `CHK("add sec", 32'h9, rq)
        tset(32'h1, 32'hffff_0000, 32'h0000_2009);
        rd(PTCRS_TIME_SEC_OFS);
        `CHK("sub sec", 32'h7, rq)
        rd(PTCRS_TIME_SUBSEC_OFS);
        `CHK("sub subsec", 32'h0001_1134, rq)
        wr(PTCRS_SUBSEC_INC_OFS, 32'h80);
        step;
        `CHK("coarse step", 32'h300, rq)
        tset(32'h5, 32'h7fff_ff00, 32'h0000_2005);
        wt;
        rd(PTCRS_TIME_SEC_OFS);
        `CHK("binary roll", 32'h6, rq)
        tset(32'h0, 32'h3b9a_c900, 32'h0000_2205);
        wt;
        rd(PTCRS_TIME_SEC_OFS);
        `CHK("decimal roll", 32'h1, rq)
        wr(PTCRS_ADDEND_OFS, 32'h8000_0000);
        wr(PTCRS_SUBSEC_INC_OFS, 32'h1);
        rd(CT);
        `CHK("addend idle", 1'b0, rq[5])
        wr(CT, 32'h0000_2023);
        rd(CT);
        `CHK("addend clear", 32'h0000_2003, rq)
        step;
        `CHK("fine step", 32'h3, rq)
        wr(PTCRS_TARGET_SEC_OFS, 32'hffff_ffff);
        wr(CT, 32'h0000_2013);
        wt;
        `CHK("no early target", 1'b0, hit)
        wr(PTCRS_TARGET_SEC_OFS, 32'h0);
        wt;
        `CHK("target irq", 1'b1, hit)
        rd(CT);
        `CHK("target en clear", 32'h0000_2003, rq)
    endtask : t_time

    // Ethertype filter flag, message table, transports, version
    task automatic t_filter;
        wr(CT, 32'h0004_2401);
        rx_ethertype <= 16'h88f7;
        repeat (2) @(posedge pclk);
        `CHK("filter on", 1'b1, timing_frame_addr_filter_en)
        rx_ethertype <= 16'h0800;
        repeat (2) @(posedge pclk);
        `CHK("filter off", 1'b0, timing_frame_addr_filter_en)
        for (int i = 0; i < 16; i++)
        begin
            wr(CT, 32'h0000_2401 | (32'(i) << 14));
            for (int j = 0; j < 7; j++)
            begin
                frm(7'h0c, 4'h2, msgs[j]);
                `CHK("msg snap", exp_snap(4'(i), msgs[j]), snap)
            end
        end
        tc(32'h2401, 7'h0a, 4'h2, 1'b0);
        tc(32'h1401, 7'h0a, 4'h2, 1'b1);
        tc(32'h0c01, 7'h09, 4'h2, 1'b1);
        tc(32'h0c01, 7'h0c, 4'h2, 1'b0);
        tc(32'h2401, 7'h0c, 4'h1, 1'b0);
        tc(32'h2001, 7'h0c, 4'h1, 1'b1);
        tc(32'h2101, 7'h00, 4'h0, 1'b1);
        tc(32'h2400, 7'h0c, 4'h2, 1'b0);
    endtask : t_filter

    task automatic final_report;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    // Main sequence after a four-cycle reset
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_count;
        t_time;
        t_filter;
        final_report;
    end
    // Hang guard
    initial
    begin
        #100000;
        err_count++;
        final_report;
    end
endmodule : ptp_timestamp_ctrl_rx_stats_bench

// ===== verilog/ptcrs_pkg.sv
// Constants for the timestamp control and receive statistics block
package ptcrs_pkg;
    // Register byte offsets
    localparam logic [11:0] PTCRS_CRC_ERR_CNT_OFS = 12'h194;
    localparam logic [11:0] PTCRS_ALIGN_ERR_CNT_OFS = 12'h198;
    localparam logic [11:0] PTCRS_GOOD_UCAST_CNT_OFS = 12'h1c4;
    localparam logic [11:0] PTCRS_CNT_STATUS_OFS = 12'h108;
    localparam logic [11:0] PTCRS_CNT_MASK_OFS = 12'h10c;
    localparam logic [11:0] PTCRS_TS_CTRL_OFS = 12'h700;
    localparam logic [11:0] PTCRS_SUBSEC_INC_OFS = 12'h704;
    localparam logic [11:0] PTCRS_TIME_SEC_OFS = 12'h708;
    localparam logic [11:0] PTCRS_TIME_SUBSEC_OFS = 12'h70c;
    localparam logic [11:0] PTCRS_ADJ_SEC_OFS = 12'h710;
    localparam logic [11:0] PTCRS_ADJ_SUBSEC_OFS = 12'h714;
    localparam logic [11:0] PTCRS_ADDEND_OFS = 12'h718;
    localparam logic [11:0] PTCRS_TARGET_SEC_OFS = 12'h71c;
    localparam logic [11:0] PTCRS_TARGET_SUBSEC_OFS = 12'h720;
    // Control reset value and write mask
    localparam logic [31:0] PTCRS_TS_CTRL_RESET = 32'h0000_2000;
    localparam logic [31:0] PTCRS_TS_CTRL_WMASK = 32'h0007_ff3f;
    // Control field positions
    localparam int PTCRS_B_ADDR_FILT = 18;
    localparam int PTCRS_B_NODE_LO = 16;
    localparam int PTCRS_B_MASTER = 15;
    localparam int PTCRS_B_EVENT = 14;
    localparam int PTCRS_B_IPV4 = 13;
    localparam int PTCRS_B_IPV6 = 12;
    localparam int PTCRS_B_RAW = 11;
    localparam int PTCRS_B_VER = 10;
    localparam int PTCRS_B_ROLL = 9;
    localparam int PTCRS_B_ALL = 8;
    localparam int PTCRS_B_ADDEND = 5;
    localparam int PTCRS_B_TGT_EN = 4;
    localparam int PTCRS_B_ADJ = 3;
    localparam int PTCRS_B_INIT = 2;
    localparam int PTCRS_B_FINE = 1;
    localparam int PTCRS_B_EN = 0;
    // Counter half-max flag positions in status and mask
    localparam int PTCRS_B_CRC_HALF = 5;
    localparam int PTCRS_B_ALIGN_HALF = 6;
    localparam int PTCRS_B_UCAST_HALF = 17;
    // Subsecond rollover limits
    localparam logic [31:0] PTCRS_BIN_LIMIT = 32'h7fff_ffff;
    localparam logic [31:0] PTCRS_DEC_LIMIT = 32'h3b9a_c9ff;
    // Timing ethertype and version codes
    localparam logic [15:0] PTCRS_PTP_ETHERTYPE = 16'h88f7;
    localparam logic [3:0] PTCRS_VER_ONE = 4'h1;
    localparam logic [3:0] PTCRS_VER_TWO = 4'h2;
    // Clock node types
    typedef enum logic [1:0] {
        PTCRS_NODE_ORD = 2'h0,
        PTCRS_NODE_BND = 2'h1,
        PTCRS_NODE_E2E = 2'h2,
        PTCRS_NODE_P2P = 2'h3
    } ptcrs_node_type;
    // Timing message type codes
    localparam logic [3:0] PTCRS_MSG_SYNC = 4'h0;
    localparam logic [3:0] PTCRS_MSG_DELAY_REQ = 4'h1;
    localparam logic [3:0] PTCRS_MSG_PDELAY_REQ = 4'h2;
    localparam logic [3:0] PTCRS_MSG_PDELAY_RESP = 4'h3;
    localparam logic [3:0] PTCRS_MSG_FOLLOW_UP = 4'h8;
    localparam logic [3:0] PTCRS_MSG_DELAY_RESP = 4'h9;
endpackage : ptcrs_pkg

// ===== verilog/ptcrs_top.sv
// Timestamp control, system time and receive statistics counters
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module ptcrs_top
    import ptcrs_pkg::*;
#(
    parameter int CNT_WIDTH = 32
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Received frame status
    input wire logic rx_frame_done,
    input wire logic rx_crc_error,
    input wire logic rx_align_error,
    input wire logic rx_good_unicast,
    input wire logic [15:0] rx_ethertype,
    // Received timing message indications
    input wire logic rx_is_ptp,
    input wire logic rx_ptp_ipv4,
    input wire logic rx_ptp_ipv6,
    input wire logic rx_ptp_raw,
    input wire logic [3:0] rx_ptp_version,
    input wire logic [3:0] rx_ptp_msg_type,
    // Timestamp and counter interrupt outputs
    output logic timestamping_enable,
    output logic timing_frame_addr_filter_en,
    output logic snapshot_take,
    output logic [31:0] snapshot_seconds,
    output logic [30:0] snapshot_subseconds,
    output logic target_time_irq,
    output logic counter_irq
);
    // Registers
    logic [31:0] ctl_q;
    logic [7:0] subsec_inc_q;
    logic [31:0] adj_sec_q;
    logic [31:0] adj_sub_q;
    logic [31:0] addend_q;
    logic [31:0] addend_active_q;
    logic [31:0] accum_q;
    logic [31:0] tgt_sec_q;
    logic [31:0] tgt_sub_q;
    logic [31:0] cnt_mask_q;
    logic [31:0] sec_q;
    logic [30:0] subsec_q;
    logic [CNT_WIDTH-1:0] cnt_q [3];
    logic [2:0] cnt_evt;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic snap_q;
    logic [31:0] snap_sec_q;
    logic [30:0] snap_sub_q;
    logic tgt_irq_q;
    logic cnt_irq_q;
    logic filt_q;
    // Decoded strobes and time arithmetic
    logic wr_en;
    logic setup;
    logic [31:0] limit;
    logic [32:0] acc_sum;
    logic tick;
    logic [31:0] run_sum;
    logic [31:0] run_sub;
    logic run_carry;
    logic [31:0] add_sub;
    logic [31:0] dif_sub;
    logic do_init;
    logic do_adj;
    logic do_addend;
    logic tgt_hit;
    logic msg_ok;
    logic snap_now;
    logic [2:0] half_flags;

    // APB phase decode
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready_q && pwrite;

    // Subsecond rollover limit per mode
    assign limit = ctl_q[PTCRS_B_ROLL] ? PTCRS_DEC_LIMIT : PTCRS_BIN_LIMIT;

    // Fine accumulator and increment tick
    assign acc_sum = {1'b0, accum_q} + {1'b0, addend_active_q};
    assign tick = ctl_q[PTCRS_B_FINE] ? acc_sum[32] : 1'b1;

    // Running time advance with rollover
    always_comb
    begin
        run_sum = {1'b0, subsec_q} + {24'h0, subsec_inc_q};
        run_carry = run_sum > limit;
        run_sub = run_carry ? run_sum - limit - 32'h1 : run_sum;
    end

    // Adjust arithmetic, add or subtract
    always_comb
    begin
        add_sub = {1'b0, subsec_q} + {1'b0, adj_sub_q[30:0]};
        dif_sub = {1'b0, subsec_q} - {1'b0, adj_sub_q[30:0]};
        if ({1'b0, adj_sub_q[30:0]} > {1'b0, subsec_q})
        begin
            dif_sub = dif_sub + limit + 32'h1;
        end
    end

    // Requests; init and adjust acted on only while timestamping is on, addend and target regardless
    assign do_init = ctl_q[PTCRS_B_EN] && ctl_q[PTCRS_B_INIT];
    assign do_adj = ctl_q[PTCRS_B_EN] && ctl_q[PTCRS_B_ADJ] && !ctl_q[PTCRS_B_INIT];
    assign do_addend = ctl_q[PTCRS_B_ADDEND];
    assign tgt_hit = ctl_q[PTCRS_B_TGT_EN] && ({sec_q, subsec_q} >= {tgt_sec_q, tgt_sub_q[30:0]});

    // Message type table per node type
    always_comb
    begin
        msg_ok = 1'b0;
        case (ptcrs_node_type'(ctl_q[PTCRS_B_NODE_LO +: 2]))
            PTCRS_NODE_ORD, PTCRS_NODE_BND:
            begin
                if (!ctl_q[PTCRS_B_EVENT])
                    msg_ok = rx_ptp_msg_type == PTCRS_MSG_SYNC
                        || rx_ptp_msg_type == PTCRS_MSG_FOLLOW_UP
                        || rx_ptp_msg_type == PTCRS_MSG_DELAY_REQ
                        || rx_ptp_msg_type == PTCRS_MSG_DELAY_RESP;
                else if (ctl_q[PTCRS_B_MASTER])
                    msg_ok = rx_ptp_msg_type == PTCRS_MSG_DELAY_REQ;
                else
                    msg_ok = rx_ptp_msg_type == PTCRS_MSG_SYNC;
            end
            PTCRS_NODE_E2E:
            begin
                if (!ctl_q[PTCRS_B_EVENT])
                    msg_ok = rx_ptp_msg_type == PTCRS_MSG_SYNC
                        || rx_ptp_msg_type == PTCRS_MSG_FOLLOW_UP
                        || rx_ptp_msg_type == PTCRS_MSG_DELAY_REQ
                        || rx_ptp_msg_type == PTCRS_MSG_DELAY_RESP;
                else
                    msg_ok = rx_ptp_msg_type == PTCRS_MSG_SYNC
                        || rx_ptp_msg_type == PTCRS_MSG_FOLLOW_UP;
            end
            default:
            begin
                if (!ctl_q[PTCRS_B_EVENT])
                    msg_ok = rx_ptp_msg_type == PTCRS_MSG_SYNC
                        || rx_ptp_msg_type == PTCRS_MSG_FOLLOW_UP
                        || rx_ptp_msg_type == PTCRS_MSG_DELAY_REQ
                        || rx_ptp_msg_type == PTCRS_MSG_DELAY_RESP
                        || rx_ptp_msg_type == PTCRS_MSG_PDELAY_REQ
                        || rx_ptp_msg_type == PTCRS_MSG_PDELAY_RESP;
                else
                    msg_ok = rx_ptp_msg_type == PTCRS_MSG_SYNC
                        || rx_ptp_msg_type == PTCRS_MSG_PDELAY_REQ
                        || rx_ptp_msg_type == PTCRS_MSG_PDELAY_RESP;
            end
        endcase
    end

    // Snapshot decision for the finished frame
    always_comb
    begin
        snap_now = 1'b0;
        if (rx_frame_done && ctl_q[PTCRS_B_EN])
        begin
            if (ctl_q[PTCRS_B_ALL])
                snap_now = 1'b1;
            else if (rx_is_ptp && msg_ok)
                snap_now = ((rx_ptp_ipv4 && ctl_q[PTCRS_B_IPV4])
                    || (rx_ptp_ipv6 && ctl_q[PTCRS_B_IPV6])
                    || (rx_ptp_raw && ctl_q[PTCRS_B_RAW]))
                    && (rx_ptp_version == (ctl_q[PTCRS_B_VER] ? PTCRS_VER_TWO
                    : PTCRS_VER_ONE));
        end
    end

    // Timestamp control register with hardware clears
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctl_q <= PTCRS_TS_CTRL_RESET;
        else
        begin
            if (wr_en && paddr == PTCRS_TS_CTRL_OFS)
                ctl_q <= pwdata & PTCRS_TS_CTRL_WMASK;
            else
            begin
                if (do_init)
                    ctl_q[PTCRS_B_INIT] <= 1'b0;
                if (do_adj)
                    ctl_q[PTCRS_B_ADJ] <= 1'b0;
                if (do_addend)
                    ctl_q[PTCRS_B_ADDEND] <= 1'b0;
                if (tgt_hit)
                    ctl_q[PTCRS_B_TGT_EN] <= 1'b0;
            end
        end
    end

    // Software written configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            subsec_inc_q <= 8'h0;
            adj_sec_q <= 32'h0;
            adj_sub_q <= 32'h0;
            addend_q <= 32'h0;
            tgt_sec_q <= 32'h0;
            tgt_sub_q <= 32'h0;
            cnt_mask_q <= 32'h0;
        end
        else if (wr_en)
        begin
            if (paddr == PTCRS_SUBSEC_INC_OFS)
                subsec_inc_q <= pwdata[7:0];
            else if (paddr == PTCRS_ADJ_SEC_OFS)
                adj_sec_q <= pwdata;
            else if (paddr == PTCRS_ADJ_SUBSEC_OFS)
                adj_sub_q <= pwdata;
            else if (paddr == PTCRS_ADDEND_OFS)
                addend_q <= pwdata;
            else if (paddr == PTCRS_TARGET_SEC_OFS)
                tgt_sec_q <= pwdata;
            else if (paddr == PTCRS_TARGET_SUBSEC_OFS)
                tgt_sub_q <= {1'b0, pwdata[30:0]};
            else if (paddr == PTCRS_CNT_MASK_OFS)
                cnt_mask_q <= pwdata & ((32'h1 << PTCRS_B_CRC_HALF)
                    | (32'h1 << PTCRS_B_ALIGN_HALF) | (32'h1 << PTCRS_B_UCAST_HALF));
        end
    end

    // Addend transfer and fine accumulator
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addend_active_q <= 32'h0;
            accum_q <= 32'h0;
        end
        else
        begin
            if (do_addend)
                addend_active_q <= addend_q;
            if (ctl_q[PTCRS_B_EN] && ctl_q[PTCRS_B_FINE])
                accum_q <= acc_sum[31:0];
        end
    end

    // System time: init, adjust, or free run
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sec_q <= 32'h0;
            subsec_q <= 31'h0;
        end
        else if (do_init)
        begin
            sec_q <= adj_sec_q;
            subsec_q <= adj_sub_q[30:0];
        end
        else if (do_adj)
        begin
            if (!adj_sub_q[31])
            begin
                if (add_sub > limit)
                begin
                    subsec_q <= 31'(add_sub - limit - 32'h1);
                    sec_q <= sec_q + adj_sec_q + 32'h1;
                end
                else
                begin
                    subsec_q <= add_sub[30:0];
                    sec_q <= sec_q + adj_sec_q;
                end
            end
            else
            begin
                subsec_q <= dif_sub[30:0];
                sec_q <= sec_q - adj_sec_q
                    - {31'h0, ({1'b0, adj_sub_q[30:0]} > {1'b0, subsec_q})};
            end
        end
        else if (ctl_q[PTCRS_B_EN] && tick)
        begin
            subsec_q <= run_sub[30:0];
            if (run_carry)
                sec_q <= sec_q + 32'h1;
        end
    end

    // Statistics counter events
    assign cnt_evt[0] = rx_frame_done && rx_crc_error;
    assign cnt_evt[1] = rx_frame_done && rx_align_error;
    assign cnt_evt[2] = rx_frame_done && rx_good_unicast;

    // Receive statistics counters
    generate
        for (genvar i = 0; i < 3; i++)
        begin : g_cnt
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    cnt_q[i] <= '0;
                else if (cnt_evt[i])
                    cnt_q[i] <= cnt_q[i] + 1'b1;
            end
            assign half_flags[i] = cnt_q[i][CNT_WIDTH-1];
        end
    endgenerate

    // Snapshot, target and counter interrupt outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            snap_q <= 1'b0;
            snap_sec_q <= 32'h0;
            snap_sub_q <= 31'h0;
            tgt_irq_q <= 1'b0;
            cnt_irq_q <= 1'b0;
            filt_q <= 1'b0;
        end
        else
        begin
            snap_q <= snap_now;
            if (snap_now)
            begin
                snap_sec_q <= sec_q;
                snap_sub_q <= subsec_q;
            end
            tgt_irq_q <= tgt_hit;
            cnt_irq_q <= (half_flags[0] && !cnt_mask_q[PTCRS_B_CRC_HALF])
                || (half_flags[1] && !cnt_mask_q[PTCRS_B_ALIGN_HALF])
                || (half_flags[2] && !cnt_mask_q[PTCRS_B_UCAST_HALF]);
            filt_q <= ctl_q[PTCRS_B_ADDR_FILT]
                && rx_ethertype == PTCRS_PTP_ETHERTYPE;
        end
    end

    // APB read data and answer, registered from the setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= setup;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
            if (setup)
            begin
                if (paddr == PTCRS_CRC_ERR_CNT_OFS)
                    prdata_q <= 32'(cnt_q[0]);
                else if (paddr == PTCRS_ALIGN_ERR_CNT_OFS)
                    prdata_q <= 32'(cnt_q[1]);
                else if (paddr == PTCRS_GOOD_UCAST_CNT_OFS)
                    prdata_q <= 32'(cnt_q[2]);
                else if (paddr == PTCRS_CNT_STATUS_OFS)
                    prdata_q <= ({31'h0, half_flags[0]} << PTCRS_B_CRC_HALF)
                        | ({31'h0, half_flags[1]} << PTCRS_B_ALIGN_HALF)
                        | ({31'h0, half_flags[2]} << PTCRS_B_UCAST_HALF);
                else if (paddr == PTCRS_CNT_MASK_OFS)
                    prdata_q <= cnt_mask_q;
                else if (paddr == PTCRS_TS_CTRL_OFS)
                    prdata_q <= ctl_q;
                else if (paddr == PTCRS_SUBSEC_INC_OFS)
                    prdata_q <= {24'h0, subsec_inc_q};
                else if (paddr == PTCRS_TIME_SEC_OFS)
                    prdata_q <= sec_q;
                else if (paddr == PTCRS_TIME_SUBSEC_OFS)
                    prdata_q <= {1'b0, subsec_q};
                else if (paddr == PTCRS_ADJ_SEC_OFS)
                    prdata_q <= adj_sec_q;
                else if (paddr == PTCRS_ADJ_SUBSEC_OFS)
                    prdata_q <= adj_sub_q;
                else if (paddr == PTCRS_ADDEND_OFS)
                    prdata_q <= addend_q;
                else if (paddr == PTCRS_TARGET_SEC_OFS)
                    prdata_q <= tgt_sec_q;
                else if (paddr == PTCRS_TARGET_SUBSEC_OFS)
                    prdata_q <= tgt_sub_q;
                else
                    pslverr_q <= 1'b1; // Unmapped address
            end
        end
    end

    // Output drive
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign timestamping_enable = ctl_q[PTCRS_B_EN];
    assign timing_frame_addr_filter_en = filt_q;
    assign snapshot_take = snap_q;
    assign snapshot_seconds = snap_sec_q;
    assign snapshot_subseconds = snap_sub_q;
    assign target_time_irq = tgt_irq_q;
    assign counter_irq = cnt_irq_q;
endmodule : ptcrs_top
